/* logic/pfc_pkg.sv */
`default_nettype none
package pfc_pkg;
  localparam logic [6:0]  ADDR_FIFO    = 7'h00;
  localparam logic [6:0]  ADDR_RATE_HI = 7'h03;
  localparam logic [6:0]  ADDR_RATE_LO = 7'h04;
  localparam logic [7:0]  RATE_HI_RST  = 8'h1a;
  localparam logic [7:0]  RATE_LO_RST  = 8'h0b;
  localparam logic [1:0]  CODE_MANCH   = 2'h1;
  localparam logic [1:0]  CODE_WHITE   = 2'h2;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_INIT     = 16'h1d0f;
  localparam logic [15:0] CRC_XOROUT   = 16'hffff;
  localparam logic [8:0]  LFSR_SEED    = 9'h1ff;
  localparam int          LFSR_TAP     = 5;
  localparam int          FIFO_DEPTH   = 8;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_FETCH = 4'h2,
    TX_SEND  = 4'h4,
    TX_DONE  = 4'h8
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_BITS = 3'h2,
    RX_DONE = 3'h4
  } rx_state_e;
endpackage : pfc_pkg
`default_nettype wire

/* logic/packet_filter_crc_balance_coding_select.sv */
// Behaviour
// - variable length: accept only length below limit
// - length byte stays in fifo
// - checksum only while checksum_enable set
// - transmit appends two checksum bytes after payload
// - receive compares checksum, sets pass flag
// - failure clears fifo, no interrupt by default
// - clear disabled: keep data, raise done irq
// - received checksum bytes never enter fifo
// - checksum uses ccitt polynomial
// - manchester only for select 01, packet mode
// - one sent as 10, zero as 01
// - only payload and checksum are manchester coded
// - all chips at the one programmed rate
// - fifo holds plain nrz bytes
// - whitening for select 10, 9-bit lfsr
// - payload and checksum xored both directions
// - lfsr polynomial x9 + x5 + 1
// - done irq once payload sits in fifo
`default_nettype none
module pfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule : pfc_fifo

module packet_filter_crc_balance_coding_select (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       packet_mode,
  input  wire logic       variable_length,
  input  wire logic [7:0] max_length_limit,
  input  wire logic       checksum_enable,
  input  wire logic       fail_clear_disable,
  input  wire logic [1:0] balance_coding_select,
  input  wire logic       tx_start,
  output logic            tx_chip,
  output logic            tx_chip_strobe,
  output logic            tx_busy,
  output logic            tx_sent,
  input  wire logic       rx_enable,
  input  wire logic       rx_payload_start,
  input  wire logic       rx_chip,
  input  wire logic       rx_chip_strobe,
  output logic            packet_done_irq,
  output logic            checksum_pass_flag,
  output logic            rx_overrun
);
  // ****************************************
  // reset, registers, fifo
  // ****************************************
  logic       rst_s1_q;
  logic       rst_sync_n;
  logic [7:0] bit_rate_high_q;
  logic [7:0] bit_rate_low_q;
  logic [15:0] chip_period;
  logic [15:0] div_q;
  logic       manch;
  logic       white;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic       flush_q;
  logic       host_pop;
  logic       host_push;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end
  assign manch = packet_mode && balance_coding_select == pfc_pkg::CODE_MANCH;
  assign white = balance_coding_select == pfc_pkg::CODE_WHITE;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      bit_rate_high_q <= pfc_pkg::RATE_HI_RST;
      bit_rate_low_q  <= pfc_pkg::RATE_LO_RST;
    end
    else if (reg_wr && reg_addr == pfc_pkg::ADDR_RATE_HI)
      bit_rate_high_q <= reg_wdata;
    else if (reg_wr && reg_addr == pfc_pkg::ADDR_RATE_LO)
      bit_rate_low_q <= reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        // a byte the transmit engine is taking this cycle must not reach the host too
        pfc_pkg::ADDR_FIFO:    reg_rdata <= (fifo_out_valid && host_pop) ? fifo_out_data : 8'h00;
        pfc_pkg::ADDR_RATE_HI: reg_rdata <= bit_rate_high_q;
        pfc_pkg::ADDR_RATE_LO: reg_rdata <= bit_rate_low_q;
        default:               reg_rdata <= 8'h00;
      endcase
  end
  // ****************************************
  // transmit path
  // ****************************************
  pfc_pkg::tx_state_e tx_st_q;
  logic [7:0]  tx_sh_q;
  logic [2:0]  tx_bit_q;
  logic        tx_half_q;
  logic        tx_first_q;
  logic        tx_crcph_q;
  logic        tx_crcb_q;
  logic [7:0]  tx_rem_q;
  logic [15:0] tx_crc_q;
  logic [15:0] tx_crc_nx;
  logic [8:0]  tx_lfsr_q;
  logic        tx_wbit;
  logic        chip_tick;
  logic        bit_end;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? pfc_pkg::CRC_POLY : 16'h0000);
  endfunction : crc_step
  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    lfsr_step = {l[0] ^ l[pfc_pkg::LFSR_TAP], l[8:1]};
  endfunction : lfsr_step
  // a zero setting would stall the chip clock, so it counts as one cycle
  assign chip_period = ({bit_rate_high_q, bit_rate_low_q} == 16'h0000) ? 16'h0001
                     : {bit_rate_high_q, bit_rate_low_q};
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      div_q <= 16'h0000;
    else if (tx_st_q == pfc_pkg::TX_IDLE || div_q == 16'h0000)
      div_q <= chip_period - 16'h0001;
    else
      div_q <= div_q - 16'h0001;
  end
  assign chip_tick = tx_st_q == pfc_pkg::TX_SEND && div_q == 16'h0000;
  assign bit_end   = chip_tick && (!manch || tx_half_q);
  assign tx_wbit   = tx_sh_q[7] ^ (white & tx_lfsr_q[0]);
  assign tx_crc_nx = crc_step(tx_crc_q, tx_sh_q[7]);
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_st_q    <= pfc_pkg::TX_IDLE;
      tx_sh_q    <= 8'h00;
      tx_bit_q   <= 3'h0;
      tx_half_q  <= 1'b0;
      tx_first_q <= 1'b0;
      tx_crcph_q <= 1'b0;
      tx_crcb_q  <= 1'b0;
      tx_rem_q   <= 8'h00;
      tx_crc_q   <= pfc_pkg::CRC_INIT;
      tx_lfsr_q  <= pfc_pkg::LFSR_SEED;
    end
    else
      case (tx_st_q)
        pfc_pkg::TX_IDLE:
        begin
          if (tx_start && !rx_enable)
          begin
            tx_st_q    <= pfc_pkg::TX_FETCH;
            tx_first_q <= 1'b1;
            tx_crcph_q <= 1'b0;
            tx_crc_q   <= pfc_pkg::CRC_INIT;
            tx_lfsr_q  <= pfc_pkg::LFSR_SEED;
          end
        end
        pfc_pkg::TX_FETCH:
        begin
          // an empty fifo just holds the engine here until the host refills
          if (fifo_out_valid)
          begin
            tx_st_q    <= pfc_pkg::TX_SEND;
            tx_sh_q    <= fifo_out_data;
            tx_bit_q   <= 3'h0;
            tx_half_q  <= 1'b0;
            tx_first_q <= 1'b0;
            if (!tx_first_q)
              tx_rem_q <= tx_rem_q - 8'h01;
            else if (variable_length)
              tx_rem_q <= fifo_out_data;
            else
              tx_rem_q <= max_length_limit - 8'h01;
          end
        end
        pfc_pkg::TX_SEND:
        begin
          if (chip_tick)
            tx_half_q <= manch && !tx_half_q;
          if (bit_end)
          begin
            tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
            tx_bit_q  <= tx_bit_q + 3'h1;
            tx_lfsr_q <= lfsr_step(tx_lfsr_q);
            if (!tx_crcph_q)
              tx_crc_q <= tx_crc_nx;
            if (tx_bit_q == 3'h7)
            begin
              if (!tx_crcph_q && tx_rem_q != 8'h00)
                tx_st_q <= pfc_pkg::TX_FETCH;
              else if (!tx_crcph_q && checksum_enable)
              begin
                tx_crcph_q <= 1'b1;
                tx_crcb_q  <= 1'b0;
                tx_sh_q    <= tx_crc_nx[15:8] ^ pfc_pkg::CRC_XOROUT[15:8];
              end
              else if (tx_crcph_q && !tx_crcb_q)
              begin
                tx_crcb_q <= 1'b1;
                tx_sh_q   <= tx_crc_q[7:0] ^ pfc_pkg::CRC_XOROUT[7:0];
              end
              else
                tx_st_q <= pfc_pkg::TX_DONE;
            end
          end
        end
        pfc_pkg::TX_DONE: tx_st_q <= pfc_pkg::TX_IDLE;
        default:          tx_st_q <= pfc_pkg::TX_IDLE;
      endcase
  end
  // preamble and sync are sent nrz by the framer ahead of this block
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_chip        <= 1'b0;
      tx_chip_strobe <= 1'b0;
      tx_busy        <= 1'b0;
      tx_sent        <= 1'b0;
    end
    else
    begin
      if (chip_tick)
        tx_chip <= tx_wbit ^ (manch & tx_half_q);
      tx_chip_strobe <= chip_tick;
      tx_busy        <= tx_st_q != pfc_pkg::TX_IDLE;
      tx_sent        <= tx_st_q == pfc_pkg::TX_DONE;
    end
  end
  // ****************************************
  // receive path
  // ****************************************
  pfc_pkg::rx_state_e rx_st_q;
  logic [7:0]  rx_sh_q;
  logic [2:0]  rx_bit_q;
  logic        rx_half_q;
  logic        rx_first_q;
  logic        rx_crcph_q;
  logic        rx_crcb_q;
  logic        rx_pass_q;
  logic [7:0]  rx_rem_q;
  logic [7:0]  rx_rem_nx;
  logic [15:0] rx_crc_q;
  logic [7:0]  rx_got_q;
  logic [8:0]  rx_lfsr_q;
  logic        rx_pend_q;
  logic [7:0]  rx_byte_q;
  logic        rx_take;
  logic        rx_d;
  logic        rx_full;
  logic [7:0]  rx_byte;
  logic        rx_len_bad;
  logic        rx_push_ev;
  assign rx_take    = rx_st_q == pfc_pkg::RX_BITS && rx_chip_strobe && (!manch || !rx_half_q);
  assign rx_d       = rx_chip ^ (white & rx_lfsr_q[0]);
  assign rx_full    = rx_take && rx_bit_q == 3'h7;
  assign rx_byte    = {rx_sh_q[6:0], rx_d};
  assign rx_len_bad = rx_first_q && variable_length && rx_byte >= max_length_limit;
  assign rx_push_ev = rx_full && !rx_crcph_q && !rx_len_bad;
  assign rx_rem_nx  = !rx_first_q ? rx_rem_q - 8'h01
                    : variable_length ? rx_byte : max_length_limit - 8'h01;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_st_q         <= pfc_pkg::RX_IDLE;
      rx_sh_q         <= 8'h00;
      rx_bit_q        <= 3'h0;
      rx_half_q       <= 1'b0;
      rx_first_q      <= 1'b0;
      rx_crcph_q      <= 1'b0;
      rx_crcb_q       <= 1'b0;
      rx_pass_q       <= 1'b0;
      rx_rem_q        <= 8'h00;
      rx_crc_q        <= pfc_pkg::CRC_INIT;
      rx_got_q        <= 8'h00;
      rx_lfsr_q       <= pfc_pkg::LFSR_SEED;
      flush_q         <= 1'b0;
      packet_done_irq <= 1'b0;
      checksum_pass_flag <= 1'b0;
    end
    else
    begin
      flush_q         <= 1'b0;
      packet_done_irq <= 1'b0;
      case (rx_st_q)
        pfc_pkg::RX_IDLE:
        begin
          if (rx_enable && rx_payload_start)
          begin
            rx_st_q    <= pfc_pkg::RX_BITS;
            rx_bit_q   <= 3'h0;
            rx_half_q  <= 1'b0;
            rx_first_q <= 1'b1;
            rx_crcph_q <= 1'b0;
            rx_crcb_q  <= 1'b0;
            rx_crc_q   <= pfc_pkg::CRC_INIT;
            rx_lfsr_q  <= pfc_pkg::LFSR_SEED;
          end
        end
        pfc_pkg::RX_BITS:
        begin
          if (rx_chip_strobe && manch)
            rx_half_q <= !rx_half_q;
          if (rx_take)
          begin
            rx_sh_q   <= rx_byte;
            rx_bit_q  <= rx_bit_q + 3'h1;
            rx_lfsr_q <= lfsr_step(rx_lfsr_q);
            if (!rx_crcph_q)
              rx_crc_q <= crc_step(rx_crc_q, rx_d);
          end
          if (!rx_enable)
            rx_st_q <= pfc_pkg::RX_IDLE;
          else if (rx_full && rx_crcph_q)
          begin
            rx_got_q  <= rx_byte;
            rx_crcb_q <= 1'b1;
            if (rx_crcb_q)
            begin
              rx_pass_q <= {rx_got_q, rx_byte} == (rx_crc_q ^ pfc_pkg::CRC_XOROUT);
              rx_st_q   <= pfc_pkg::RX_DONE;
            end
          end
          else if (rx_full && rx_len_bad)
          begin
            flush_q <= 1'b1;
            rx_st_q <= pfc_pkg::RX_IDLE;
          end
          else if (rx_full)
          begin
            rx_first_q <= 1'b0;
            rx_rem_q   <= rx_rem_nx;
            if (rx_rem_nx == 8'h00 && checksum_enable)
              rx_crcph_q <= 1'b1;
            else if (rx_rem_nx == 8'h00)
            begin
              rx_pass_q <= 1'b1;
              rx_st_q   <= pfc_pkg::RX_DONE;
            end
          end
        end
        pfc_pkg::RX_DONE:
        begin
          if (!rx_pend_q)
          begin
            rx_st_q <= pfc_pkg::RX_IDLE;
            if (checksum_enable)
              checksum_pass_flag <= rx_pass_q;
            if (rx_pass_q || fail_clear_disable)
              packet_done_irq <= 1'b1;
            else
              flush_q <= 1'b1;
          end
        end
        default: rx_st_q <= pfc_pkg::RX_IDLE;
      endcase
    end
  end
  // the chip stream cannot be stalled, so one byte waits here for fifo room
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_pend_q  <= 1'b0;
      rx_byte_q  <= 8'h00;
      rx_overrun <= 1'b0;
    end
    else
    begin
      if (rx_push_ev)
      begin
        rx_pend_q <= 1'b1;
        rx_byte_q <= rx_byte;
        if (rx_pend_q && !fifo_in_ready)
          rx_overrun <= 1'b1;
      end
      else if (fifo_in_ready || flush_q)
        rx_pend_q <= 1'b0;
      if (rx_st_q == pfc_pkg::RX_IDLE && rx_payload_start)
        rx_overrun <= 1'b0;
    end
  end
  assign host_push      = reg_wr && reg_addr == pfc_pkg::ADDR_FIFO && !rx_pend_q;
  assign host_pop       = reg_rd && reg_addr == pfc_pkg::ADDR_FIFO && tx_st_q != pfc_pkg::TX_FETCH;
  assign fifo_in_valid  = rx_pend_q || host_push;
  assign fifo_in_data   = rx_pend_q ? rx_byte_q : reg_wdata;
  assign fifo_out_ready = tx_st_q == pfc_pkg::TX_FETCH || host_pop;
  pfc_fifo #(
    .WIDTH (8),
    .DEPTH (pfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .flush     (flush_q),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );
  // ****************************************
  // checks
  // ****************************************
  a_len_drop: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (rx_full && !rx_crcph_q && rx_len_bad && rx_enable)
    |=> (flush_q && rx_st_q == pfc_pkg::RX_IDLE)) else $error("bad length not dropped");
  a_len_kept: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (rx_full && rx_first_q && !rx_len_bad && !rx_crcph_q)
    |=> (rx_pend_q && rx_byte_q == $past(rx_byte))) else $error("length byte not queued");
  a_crc_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(tx_crcph_q) |-> $past(checksum_enable)) else $error("checksum sent while off");
  a_fail_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (rx_st_q == pfc_pkg::RX_DONE && !rx_pend_q && !rx_pass_q && !fail_clear_disable)
    |=> (flush_q && !packet_done_irq)) else $error("failed packet not cleared");
  a_fail_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (rx_st_q == pfc_pkg::RX_DONE && !rx_pend_q && (rx_pass_q || fail_clear_disable))
    |=> (packet_done_irq && !flush_q)) else $error("done irq missing");
  a_crc_strip: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rx_crcph_q |-> !rx_push_ev) else $error("checksum byte pushed to fifo");
  a_manch_pair: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (chip_tick && manch && tx_half_q)
    |=> (tx_chip != $past(tx_chip))) else $error("manchester chip wrong");
  a_chip_space: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (chip_tick && chip_period > 16'h0001) |=> !chip_tick) else $error("chip rate wrong");
  a_lfsr_seed: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (tx_st_q == pfc_pkg::TX_FETCH && $past(tx_st_q) == pfc_pkg::TX_IDLE)
    |-> tx_lfsr_q == pfc_pkg::LFSR_SEED) else $error("lfsr not preset");
endmodule : packet_filter_crc_balance_coding_select
`default_nettype wire

/* dv/host_model.sv */
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // host register cycles, one strobe cycle each
  // ****
  initial
  begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    // released data must not keep showing the last byte
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
    #1;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, packet_mode, variable_length, checksum_enable, fail_clear_disable;
  logic       reg_wr, reg_rd, tx_start, tx_chip, tx_chip_strobe, tx_busy, tx_sent;
  logic       rx_enable, rx_payload_start, rx_chip, rx_chip_strobe;
  logic       packet_done_irq, checksum_pass_flag, rx_overrun, last_flag;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, max_length_limit, d;
  logic [1:0] balance_coding_select;
  logic [7:0] pk[$];
  logic       exp_q[$];
  logic       got_q[$];
  integer     failures, check_count, seed, irq_n;

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  packet_filter_crc_balance_coding_select dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .packet_mode(packet_mode), .variable_length(variable_length),
    .max_length_limit(max_length_limit), .checksum_enable(checksum_enable),
    .fail_clear_disable(fail_clear_disable), .balance_coding_select(balance_coding_select),
    .tx_start(tx_start), .tx_chip(tx_chip), .tx_chip_strobe(tx_chip_strobe),
    .tx_busy(tx_busy), .tx_sent(tx_sent), .rx_enable(rx_enable),
    .rx_payload_start(rx_payload_start), .rx_chip(rx_chip), .rx_chip_strobe(rx_chip_strobe),
    .packet_done_irq(packet_done_irq), .checksum_pass_flag(checksum_pass_flag),
    .rx_overrun(rx_overrun));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (packet_done_irq === 1'b1)
      irq_n++;

  // ****
  // checking and expectation helpers
  // ****
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic make(input int n);
    pk = {n[7:0]};
    repeat (n) pk.push_back(8'($random(seed)));
  endtask : make
  // payload bits, checksum over all of them, then whitening or chip pairs
  task automatic build(input logic [1:0] m, input logic ck, input logic [15:0] bad);
    logic [15:0] c;
    logic [8:0]  l;
    logic        b[$];
    c = pfc_pkg::CRC_INIT;
    l = pfc_pkg::LFSR_SEED;
    exp_q = {};
    foreach (pk[i])
      for (int j = 7; j >= 0; j--)
        b.push_back(pk[i][j]);
    foreach (b[i])
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? pfc_pkg::CRC_POLY : 16'h0000);
    c = c ^ pfc_pkg::CRC_XOROUT ^ bad;
    if (ck)
      for (int j = 15; j >= 0; j--)
        b.push_back(c[j]);
    foreach (b[i])
    begin
      if (m == pfc_pkg::CODE_WHITE)
      begin
        b[i] = b[i] ^ l[0];
        l = {l[0] ^ l[pfc_pkg::LFSR_TAP], l[8:1]};
      end
      exp_q.push_back(b[i]);
      if (m == pfc_pkg::CODE_MANCH)
        exp_q.push_back(~b[i]);
    end
  endtask : build

  // ****
  // transmit and receive scenarios
  // ****
  task automatic tx_case(input logic [1:0] m, input logic ck);
    int k;
    int gap;
    make(3);
    foreach (pk[i])
      host.wr(pfc_pkg::ADDR_FIFO, pk[i]);
    balance_coding_select = m;
    checksum_enable = ck;
    build(m, ck, 16'h0000);
    got_q = {};
    gap = 0;
    @(posedge clk);
    #2;
    tx_start = 1'b1;
    @(posedge clk);
    #2;
    tx_start = 1'b0;
    for (k = 0; k < 4000 && tx_sent !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
      gap++;
      if (tx_chip_strobe === 1'b1)
      begin
        if (got_q.size() > 0)
          chk("chip spacing", 16'h0004, 16'(gap));
        chk("tx busy", 16'h0001, 16'(tx_busy));
        gap = 0;
        got_q.push_back(tx_chip);
      end
    end
    if (k == 4000)
    begin
      failures++;
      tally_and_finish();
    end
    @(posedge clk);
    #2;
    chk("tx busy end", 16'h0000, 16'(tx_busy));
    chk("tx chip count", 16'(exp_q.size()), 16'(got_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk("tx chip", exp_q[i], got_q[i]);
    $display("tx test mode %0d crc %0d done", m, ck);
  endtask : tx_case
  // payload start, then every expected chip with a strobe every other cycle
  task automatic feed;
    @(posedge clk);
    #2;
    rx_payload_start = 1'b1;
    @(posedge clk);
    #2;
    rx_payload_start = 1'b0;
    foreach (exp_q[i])
    begin
      rx_chip = exp_q[i];
      rx_chip_strobe = 1'b1;
      @(posedge clk);
      #2;
      rx_chip_strobe = 1'b0;
      rx_chip = ~exp_q[i];
      @(posedge clk);
      #2;
    end
    repeat (8) @(posedge clk);
    #2;
  endtask : feed
  task automatic rx_case(input logic [1:0] m, input logic ck, input logic fcd,
                         input logic [15:0] bad, input int n, input int lim, input logic acc);
    logic [7:0] e;
    make(n);
    balance_coding_select = m;
    checksum_enable = ck;
    fail_clear_disable = fcd;
    max_length_limit = lim[7:0];
    build(m, ck, bad);
    irq_n = 0;
    feed();
    chk("done irq count", 16'(acc), 16'(irq_n));
    chk("rx overrun", 16'h0000, 16'(rx_overrun));
    // a packet dropped on its length never reaches the checksum stage
    if (ck && n < lim)
      last_flag = (bad == 16'h0000);
    chk("pass flag", last_flag, checksum_pass_flag);
    for (int i = 0; i <= n + 1; i++)
    begin
      e = 8'h00;
      if (acc && i <= n)
        e = pk[i];
      host.rd(pfc_pkg::ADDR_FIFO, d);
      chk("rx fifo byte", e, d);
    end
    $display("rx test mode %0d length %0d limit %0d done", m, n, lim);
  endtask : rx_case

  initial
  begin
    seed = 32'h309f479b;
    failures = 0;
    check_count = 0;
    last_flag = 1'b0;
    rst_n = 1'b0;
    packet_mode = 1'b1;
    variable_length = 1'b1;
    max_length_limit = 8'hff;
    checksum_enable = 1'b1;
    fail_clear_disable = 1'b0;
    balance_coding_select = 2'h0;
    tx_start = 1'b0;
    rx_enable = 1'b0;
    rx_payload_start = 1'b0;
    rx_chip = 1'b0;
    rx_chip_strobe = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    host.rd(pfc_pkg::ADDR_RATE_HI, d);
    chk("rate high reset", pfc_pkg::RATE_HI_RST, d);
    host.rd(pfc_pkg::ADDR_RATE_LO, d);
    chk("rate low reset", pfc_pkg::RATE_LO_RST, d);
    host.rd(7'h11, d);
    chk("unmapped read", 8'h00, d);
    host.wr(pfc_pkg::ADDR_RATE_HI, 8'h00);
    host.wr(pfc_pkg::ADDR_RATE_LO, 8'h04);
    host.rd(pfc_pkg::ADDR_RATE_LO, d);
    chk("rate low", 8'h04, d);
    // nine bytes into eight places: the last is refused, the last read finds it empty
    make(8);
    foreach (pk[i])
      host.wr(pfc_pkg::ADDR_FIFO, pk[i]);
    foreach (pk[i])
    begin
      host.rd(pfc_pkg::ADDR_FIFO, d);
      chk("fifo fill byte", (i < 8) ? pk[i] : 8'h00, d);
    end
    $display("fifo fill test done");
    tx_case(2'h0, 1'b1);
    tx_case(2'h1, 1'b1);
    tx_case(2'h2, 1'b1);
    tx_case(2'h3, 1'b0);
    rx_enable = 1'b1;
    rx_case(2'h0, 1'b1, 1'b0, 16'h0000, 3, 255, 1'b1);
    rx_case(2'h1, 1'b1, 1'b0, 16'h0000, 3, 255, 1'b1);
    rx_case(2'h2, 1'b1, 1'b0, 16'h0000, 3, 255, 1'b1);
    rx_case(2'h0, 1'b1, 1'b0, 16'h0001, 3, 255, 1'b0);
    rx_case(2'h0, 1'b1, 1'b1, 16'h8000, 3, 255, 1'b1);
    rx_case(2'h0, 1'b0, 1'b0, 16'h0000, 3, 255, 1'b1);
    rx_case(2'h0, 1'b1, 1'b0, 16'h0000, 4, 4, 1'b0);
    rx_case(2'h0, 1'b1, 1'b0, 16'h0000, 3, 4, 1'b1);
    // host bytes fill every place: the first received byte waits, the next overwrites it and sets overrun
    make(7);
    foreach (pk[i])
      host.wr(pfc_pkg::ADDR_FIFO, pk[i]);
    make(3);
    build(2'h0, 1'b1, 16'h0000);
    feed();
    chk("rx overrun", 16'h0001, 16'(rx_overrun));
    $display("rx overrun test done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
